/* rtl/amp_ctrl_consts.svh */
`ifndef AMP_CTRL_CONSTS_SVH
`define AMP_CTRL_CONSTS_SVH

// ****************************************************************
// Timing
// ****************************************************************
`define AMP_CLK_KHZ      200000
`define AMP_DC_TRIP_MS   420
`define AMP_DC_TRIP_CYC  (`AMP_DC_TRIP_MS * `AMP_CLK_KHZ)
`define AMP_WIN_CYC      8'd100
`define AMP_WIN_LAST     8'd99
// Window is 100 cycles, so a count equals a percentage
`define AMP_DC_IMB_CNT   9'd14

// ****************************************************************
// Thermal, gain
// ****************************************************************
`define AMP_TEMP_TRIP    8'd150
`define AMP_TEMP_HYST    8'd15
`define AMP_GAIN_00      6'd20
`define AMP_GAIN_01      6'd26
`define AMP_GAIN_10      6'd32
`define AMP_GAIN_11      6'd36

// ****************************************************************
// Register map
// ****************************************************************
`define AMP_REG_CTRL     12'h000
`define AMP_REG_STAT     12'h004
`define AMP_LIM_EN_BIT   0
`define AMP_LIM_LSB      8
`define AMP_LIM_MSB      15
`define AMP_LIM_RST      8'h64
`define AMP_ST_DC        0
`define AMP_ST_OC        1
`define AMP_ST_OT        2
`define AMP_ST_SD        3
`define AMP_ST_RUN       4
`define AMP_ST_GAIN_LSB  8
`define AMP_ST_GAIN_MSB  13

`endif

/* rtl/amp_ctrl_pkg.sv */
package amp_ctrl_pkg;

    typedef logic [5:0] gain_db_t;

    typedef enum logic [3:0] {
        ST_IDLE = 4'b0001,
        ST_RUN  = 4'b0010,
        ST_HIZ  = 4'b0100,
        ST_COOL = 4'b1000
    } amp_state_e;

    typedef enum logic [1:0] {
        POL_NONE = 2'b00,
        POL_POS  = 2'b01,
        POL_NEG  = 2'b10
    } dc_pol_e;

    typedef struct packed {
        logic [7:0] run_cnt;
        logic [7:0] last_cnt;
    } meter_s;

    typedef struct packed {
        dc_pol_e     prev;
        logic [31:0] acc;
        logic        trip;
    } hold_s;

    typedef struct packed {
        amp_state_e  st;
        logic        dc;
        logic        oc;
        logic        ot;
        logic [7:0]  win;
        logic        step;
        logic        lim_en;
        logic [7:0]  lim;
        gain_db_t    gain;
        logic        out_p;
        logic        out_n;
        logic        oe_p;
        logic        oe_n;
        logic        fault;
        logic [31:0] rdata;
        logic        slverr;
    } top_s;

endpackage : amp_ctrl_pkg

/* rtl/duty_meter.sv */
`timescale 1ns/1ps
`include "amp_ctrl_consts.svh"

module duty_meter (
    input  wire logic       clk_i,      // Core clock
    input  wire logic       rst_n_i,    // Sync reset, active low
    input  wire logic       pwm_i,      // Leg drive to measure
    input  wire logic       win_end_i,  // Last cycle of a window
    output logic      [7:0] run_cnt_o,  // High cycles so far
    output logic      [7:0] last_cnt_o  // High cycles of last window
);
    import amp_ctrl_pkg::*;

    meter_s s_ff;
    meter_s nxt_s;

    always_comb begin
        nxt_s = s_ff;
        if (win_end_i) begin
            nxt_s.last_cnt = s_ff.run_cnt + {7'h00, pwm_i};
            nxt_s.run_cnt  = 8'h00;
        end else begin
            nxt_s.run_cnt = s_ff.run_cnt + {7'h00, pwm_i};
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            s_ff <= '0;
        end else begin
            s_ff <= nxt_s;
        end
    end

    assign run_cnt_o  = s_ff.run_cnt;
    assign last_cnt_o = s_ff.last_cnt;

endmodule : duty_meter

/* rtl/dc_hold_timer.sv */
`timescale 1ns/1ps
`include "amp_ctrl_consts.svh"

module dc_hold_timer #(
    parameter int unsigned TRIP_CYC = `AMP_DC_TRIP_CYC
) (
    input  wire logic                 clk_i,    // Core clock
    input  wire logic                 rst_n_i,  // Sync reset, active low
    input  wire logic                 step_i,   // One window judged
    input  wire logic                 clr_i,    // Bridge not running
    input  wire amp_ctrl_pkg::dc_pol_e pol_i,   // Polarity of that window
    output logic                      trip_o    // Imbalance held too long
);
    import amp_ctrl_pkg::*;

    hold_s s_ff;
    hold_s nxt_s;

    always_comb begin
        nxt_s = s_ff;
        if (clr_i) begin
            nxt_s.prev = POL_NONE;
            nxt_s.acc  = 32'h0;
        end else if (step_i) begin
            nxt_s.prev = pol_i;
            if (pol_i == POL_NONE) begin
                nxt_s.acc = 32'h0;
            end else if (pol_i != s_ff.prev) begin
                nxt_s.acc = {24'h0, `AMP_WIN_CYC};
            end else if (s_ff.acc <= TRIP_CYC) begin
                // Saturate just past the limit so the sum never wraps
                nxt_s.acc = s_ff.acc + {24'h0, `AMP_WIN_CYC};
            end
        end
        nxt_s.trip = (nxt_s.acc > TRIP_CYC);
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            s_ff <= '{prev: POL_NONE, default: '0};
        end else begin
            s_ff <= nxt_s;
        end
    end

    assign trip_o = s_ff.trip;

endmodule : dc_hold_timer

/* rtl/amp_ctrl_top.sv */
// Notes on behaviour
// RULE1 - Gain codes 00..11 give 20/26/32/36 dB
// RULE2 - First select pin is LSB, second MSB
// RULE3 - Shutdown low mutes bridge, idles; high runs
// RULE4 - Host always drives shutdown to defined level
// RULE5 - Host asserts shutdown before removing supply
// RULE6 - Over 14% imbalance, same polarity, 420 ms: fault
// RULE7 - Positive output: positive leg duty above half
// RULE8 - DC fault drives fault output low
// RULE9 - DC fault puts both legs high impedance
// RULE10 - DC fault held until bridge supply cycles
// RULE11 - Host holds shutdown during power-up settling
// RULE12 - Over-current latch drives fault output low
// RULE13 - Over-current latch holds legs high impedance
// RULE14 - Shutdown low then high clears over-current
// RULE15 - Fault tied to shutdown gives auto-recovery
// RULE16 - Die above 150 degrees: shut down outputs
// RULE17 - Thermal stop self-clears after 15 degrees cooling
// RULE18 - Thermal stop never asserts fault output
// RULE19 - Power limiter clamps duty to fixed maximum; here a CTRL register limit, reset 100, off until enabled
// RULE20 - Fault low while either latch set
//
// Our own choices: the APB register port and the address map.
`timescale 1ns/1ps
`include "amp_ctrl_consts.svh"

module amp_ctrl_top #(
    parameter int unsigned DC_TRIP_CYCLES = `AMP_DC_TRIP_CYC
) (
    input  wire logic                   CORE_CLK_I,          // Core clock, 200 MHz
    input  wire logic                   RESET_N_I,           // Sync reset, active low
    input  wire logic                   PSEL_I,              // APB select
    input  wire logic                   PENABLE_I,           // APB access phase
    input  wire logic                   PWRITE_I,            // APB write
    input  wire logic [11:0]            PADDR_I,             // APB byte address
    input  wire logic [31:0]            PWDATA_I,            // APB write data
    input  wire logic [3:0]             PSTRB_I,             // APB byte strobes
    output logic      [31:0]            PRDATA_O,            // APB read data
    output logic                        PREADY_O,            // APB ready
    output logic                        PSLVERR_O,           // APB error
    input  wire logic                   GAIN_SEL_LSB_I,      // Gain code bit 0
    input  wire logic                   GAIN_SEL_MSB_I,      // Gain code bit 1
    input  wire logic                   SHUTDOWN_N_I,        // Shutdown, active low
    input  wire logic                   BRIDGE_SUPPLY_OK_I,  // Bridge supply present
    input  wire logic                   SHORT_DETECT_I,      // Output over-current
    input  wire logic [7:0]             DIE_TEMP_I,          // Die temperature, deg C
    input  wire logic                   PWM_POS_I,           // Modulator positive leg
    input  wire logic                   PWM_NEG_I,           // Modulator negative leg
    output logic                        BRIDGE_OUT_POS_O,    // Positive leg level
    output logic                        BRIDGE_OUT_POS_OE_O, // Positive leg driven
    output logic                        BRIDGE_OUT_NEG_O,    // Negative leg level
    output logic                        BRIDGE_OUT_NEG_OE_O, // Negative leg driven
    output logic                        FAULT_N_O,           // Fault, open drain level
    output logic                        FAULT_N_OE_O,        // Fault pulled low
    output amp_ctrl_pkg::gain_db_t      GAIN_DB_O            // Selected gain in dB
);
    import amp_ctrl_pkg::*;

    localparam top_s RST_S = '{st: ST_IDLE, lim: `AMP_LIM_RST, default: '0};

    top_s        s_ff;
    top_s        nxt_s;
    logic [7:0]  run_cnt_p;
    logic [7:0]  run_cnt_n;
    logic [7:0]  last_cnt_p;
    logic [7:0]  last_cnt_n;
    logic        win_end;
    logic        dc_trip;
    dc_pol_e     win_pol;
    logic        apb_setup;
    logic        apb_access;
    logic        hit_ctrl;
    logic        hit_stat;
    logic        latch_any;
    logic        gate_p;
    logic        gate_n;
    logic [31:0] stat_word;

    // ************************************************************
    // Duty measurement and DC persistence
    // ************************************************************
    assign win_end = (s_ff.win == `AMP_WIN_LAST);

    duty_meter u_meter_pos (
        .clk_i      (CORE_CLK_I),
        .rst_n_i    (RESET_N_I),
        .pwm_i      (PWM_POS_I),
        .win_end_i  (win_end),
        .run_cnt_o  (run_cnt_p),
        .last_cnt_o (last_cnt_p)
    );

    duty_meter u_meter_neg (
        .clk_i      (CORE_CLK_I),
        .rst_n_i    (RESET_N_I),
        .pwm_i      (PWM_NEG_I),
        .win_end_i  (win_end),
        .run_cnt_o  (run_cnt_n),
        .last_cnt_o (last_cnt_n)
    );

    // RULE7 leg duty polarity
    always_comb begin
        win_pol = POL_NONE;
        if ({1'b0, last_cnt_p} > ({1'b0, last_cnt_n} + `AMP_DC_IMB_CNT)) begin
            win_pol = POL_POS;
        end else if ({1'b0, last_cnt_n} > ({1'b0, last_cnt_p} + `AMP_DC_IMB_CNT)) begin
            win_pol = POL_NEG;
        end
    end

    // RULE6 imbalance persistence
    dc_hold_timer #(
        .TRIP_CYC (DC_TRIP_CYCLES)
    ) u_dc_hold (
        .clk_i   (CORE_CLK_I),
        .rst_n_i (RESET_N_I),
        .step_i  (s_ff.step),
        .clr_i   (s_ff.st != ST_RUN),
        .pol_i   (win_pol),
        .trip_o  (dc_trip)
    );

    // ************************************************************
    // Register bus decode
    // ************************************************************
    assign apb_setup  = PSEL_I & ~PENABLE_I;
    assign apb_access = PSEL_I & PENABLE_I;
    assign hit_ctrl   = (PADDR_I == `AMP_REG_CTRL);
    assign hit_stat   = (PADDR_I == `AMP_REG_STAT);
    assign latch_any  = s_ff.dc | s_ff.oc;

    always_comb begin
        stat_word = 32'h0;
        stat_word[`AMP_ST_DC]  = s_ff.dc;
        stat_word[`AMP_ST_OC]  = s_ff.oc;
        stat_word[`AMP_ST_OT]  = s_ff.ot;
        stat_word[`AMP_ST_SD]  = ~SHUTDOWN_N_I;
        stat_word[`AMP_ST_RUN] = (s_ff.st == ST_RUN);
        stat_word[`AMP_ST_GAIN_MSB:`AMP_ST_GAIN_LSB] = s_ff.gain;
    end

    // RULE19 duty clamp
    assign gate_p = ~s_ff.lim_en | (run_cnt_p < s_ff.lim);
    assign gate_n = ~s_ff.lim_en | (run_cnt_n < s_ff.lim);

    // ************************************************************
    // Next state
    // ************************************************************
    always_comb begin
        nxt_s      = s_ff;
        nxt_s.win  = win_end ? 8'h00 : s_ff.win + 8'h01;
        nxt_s.step = win_end;

        // RULE1 gain decode
        // RULE2 select bit order
        case ({GAIN_SEL_MSB_I, GAIN_SEL_LSB_I})
            2'b00:   nxt_s.gain = `AMP_GAIN_00;
            2'b01:   nxt_s.gain = `AMP_GAIN_01;
            2'b10:   nxt_s.gain = `AMP_GAIN_10;
            default: nxt_s.gain = `AMP_GAIN_11;
        endcase

        // RULE16 thermal trip
        // RULE17 hysteresis release
        if (DIE_TEMP_I > `AMP_TEMP_TRIP) begin
            nxt_s.ot = 1'b1;
        end else if (DIE_TEMP_I <= (`AMP_TEMP_TRIP - `AMP_TEMP_HYST)) begin
            nxt_s.ot = 1'b0;
        end

        // RULE14 shutdown clears latch
        // Cleared during the low level, not on release: with the fault pin
        // tied back to shutdown the latch would otherwise never let go.
        if (SHORT_DETECT_I && (s_ff.st == ST_RUN)) begin
            nxt_s.oc = 1'b1;
        end else if (!SHUTDOWN_N_I) begin
            nxt_s.oc = 1'b0;
        end

        // RULE10 supply cycle clears
        if (dc_trip) begin
            nxt_s.dc = 1'b1;
        end else if (!BRIDGE_SUPPLY_OK_I) begin
            nxt_s.dc = 1'b0;
        end

        // RULE3 shutdown and recovery
        case (s_ff.st)
            ST_IDLE: begin
                if (latch_any) begin
                    nxt_s.st = ST_HIZ;
                end else if (s_ff.ot) begin
                    nxt_s.st = ST_COOL;
                end else if (SHUTDOWN_N_I && BRIDGE_SUPPLY_OK_I) begin
                    nxt_s.st = ST_RUN;
                end
            end
            ST_RUN: begin
                if (latch_any) begin
                    nxt_s.st = ST_HIZ;
                end else if (s_ff.ot) begin
                    nxt_s.st = ST_COOL;
                end else if (!SHUTDOWN_N_I || !BRIDGE_SUPPLY_OK_I) begin
                    nxt_s.st = ST_IDLE;
                end
            end
            ST_HIZ: begin
                if (!latch_any) begin
                    nxt_s.st = ST_IDLE;
                end
            end
            ST_COOL: begin
                if (latch_any) begin
                    nxt_s.st = ST_HIZ;
                end else if (!s_ff.ot) begin
                    nxt_s.st = ST_IDLE;
                end
            end
            default: nxt_s.st = ST_IDLE;
        endcase

        // RULE9 DC fault floats legs
        // RULE13 latch floats legs
        // Idle keeps legs driven low as a mute; faults and heat float them
        nxt_s.oe_p  = (nxt_s.st == ST_RUN) || (nxt_s.st == ST_IDLE);
        nxt_s.oe_n  = nxt_s.oe_p;
        nxt_s.out_p = (nxt_s.st == ST_RUN) & PWM_POS_I & gate_p;
        nxt_s.out_n = (nxt_s.st == ST_RUN) & PWM_NEG_I & gate_n;

        // RULE20 fault from either latch
        // RULE18 heat not reported
        nxt_s.fault = nxt_s.dc | nxt_s.oc;

        if (apb_setup) begin
            nxt_s.slverr = ~(hit_ctrl | hit_stat);
            nxt_s.rdata  = 32'h0;
            if (!PWRITE_I && hit_ctrl) begin
                nxt_s.rdata[`AMP_LIM_EN_BIT]            = s_ff.lim_en;
                nxt_s.rdata[`AMP_LIM_MSB:`AMP_LIM_LSB]  = s_ff.lim;
            end else if (!PWRITE_I && hit_stat) begin
                nxt_s.rdata = stat_word;
            end
        end
        if (apb_access && PWRITE_I && hit_ctrl) begin
            if (PSTRB_I[0]) begin
                nxt_s.lim_en = PWDATA_I[`AMP_LIM_EN_BIT];
            end
            if (PSTRB_I[1]) begin
                nxt_s.lim = PWDATA_I[`AMP_LIM_MSB:`AMP_LIM_LSB];
            end
        end
    end

    always_ff @(posedge CORE_CLK_I) begin
        if (!RESET_N_I) begin
            s_ff <= RST_S;
        end else begin
            s_ff <= nxt_s;
        end
    end

    // ************************************************************
    // Outputs
    // ************************************************************
    assign PREADY_O            = apb_access;
    assign PSLVERR_O           = apb_access & s_ff.slverr;
    assign PRDATA_O            = s_ff.rdata;
    assign BRIDGE_OUT_POS_O    = s_ff.out_p;
    assign BRIDGE_OUT_POS_OE_O = s_ff.oe_p;
    assign BRIDGE_OUT_NEG_O    = s_ff.out_n;
    assign BRIDGE_OUT_NEG_OE_O = s_ff.oe_n;
    // RULE15 open-drain fault pull
    assign FAULT_N_O           = 1'b0;
    // RULE8 DC fault on pin
    // RULE12 latch on pin
    assign FAULT_N_OE_O        = s_ff.fault;
    assign GAIN_DB_O           = s_ff.gain;

    // ************************************************************
    // Checks
    // ************************************************************
    default clocking cb @(posedge CORE_CLK_I); endclocking
    default disable iff (!RESET_N_I);

    sequence sd_drop_s;
        (s_ff.st == ST_RUN) && !SHUTDOWN_N_I && !latch_any && !s_ff.ot;
    endsequence

    sequence hot_s;
        (DIE_TEMP_I > `AMP_TEMP_TRIP) && !latch_any ##1 s_ff.ot;
    endsequence

    AST_GAIN_MAP: assert property ( // RULE1
        ({GAIN_SEL_MSB_I, GAIN_SEL_LSB_I} == 2'b11) |=> (GAIN_DB_O == 6'd36))
        else $error("gain code 11 not 36 dB");
    AST_GAIN_LSB: assert property ( // RULE2
        ({GAIN_SEL_MSB_I, GAIN_SEL_LSB_I} == 2'b01) |=> (GAIN_DB_O == 6'd26))
        else $error("lsb select not 26 dB");
    AST_SD_MUTE: assert property ( // RULE3
        sd_drop_s |=> (s_ff.st == ST_IDLE) && BRIDGE_OUT_POS_OE_O && !BRIDGE_OUT_POS_O
                      && BRIDGE_OUT_NEG_OE_O && !BRIDGE_OUT_NEG_O)
        else $error("shutdown did not mute bridge");
    AST_DC_TRIP: assert property ( // RULE6
        $rose(s_ff.dc) |-> $past(dc_trip))
        else $error("dc fault without persistence trip");
    AST_DC_PIN: assert property ( // RULE8
        s_ff.dc |-> FAULT_N_OE_O && !FAULT_N_O)
        else $error("dc fault not on fault pin");
    AST_DC_HIZ: assert property ( // RULE9
        $rose(s_ff.dc) |=> !BRIDGE_OUT_POS_OE_O && !BRIDGE_OUT_NEG_OE_O)
        else $error("dc fault left bridge driven");
    AST_DC_STICKY: assert property ( // RULE10
        s_ff.dc && BRIDGE_SUPPLY_OK_I |=> s_ff.dc)
        else $error("dc fault cleared without supply cycle");
    AST_OC_HIZ: assert property ( // RULE13
        s_ff.oc [*2] |-> !BRIDGE_OUT_POS_OE_O && !BRIDGE_OUT_NEG_OE_O)
        else $error("over-current left bridge driven");
    AST_OC_CLEAR: assert property ( // RULE14
        s_ff.oc && !SHUTDOWN_N_I && !SHORT_DETECT_I |=> !s_ff.oc ##1 !FAULT_N_OE_O || s_ff.dc)
        else $error("shutdown did not clear over-current");
    AST_OT_OFF: assert property ( // RULE16
        hot_s |=> !BRIDGE_OUT_POS_OE_O && !BRIDGE_OUT_NEG_OE_O)
        else $error("over-temperature left bridge driven");
    AST_OT_RESUME: assert property ( // RULE17
        s_ff.ot && (DIE_TEMP_I <= 8'd135) && !latch_any && SHUTDOWN_N_I
        && BRIDGE_SUPPLY_OK_I && !SHORT_DETECT_I
        |=> !s_ff.ot ##[1:3] (s_ff.st == ST_RUN))
        else $error("no self recovery after cooling");
    AST_OT_NOFAULT: assert property ( // RULE18
        s_ff.ot && !latch_any |-> !FAULT_N_OE_O)
        else $error("thermal stop reported as fault");
    AST_LIM_CLAMP: assert property ( // RULE19
        s_ff.lim_en && (run_cnt_p >= s_ff.lim) && !win_end |=> !BRIDGE_OUT_POS_O)
        else $error("duty clamp exceeded");
    AST_FAULT_OR: assert property ( // RULE20
        FAULT_N_OE_O == (s_ff.dc || s_ff.oc))
        else $error("fault pin disagrees with latches");

endmodule : amp_ctrl_top

/* test/amp_host_model.sv */
`timescale 1ns/1ps
// ****************************************************************
// Host side of the shutdown and gain pins
// ****************************************************************
module amp_host_model (
    input  wire logic       clk_i,        // Core clock
    input  wire logic       auto_rec_i,   // Fault pin strapped to shutdown
    input  wire logic       sd_req_n_i,   // Shutdown request, active low
    input  wire logic       fault_oe_i,   // Fault pin pulled low
    input  wire logic [1:0] gain_i,       // Requested gain code
    output logic            shutdown_n_o, // Shutdown pin level
    output logic            gain_lsb_o,   // Gain code bit 0
    output logic            gain_msb_o    // Gain code bit 1
);
    logic [1:0] gain_ff;

    // never left floating
    // Strapped mode: the pull-up holds it high unless the fault pin sinks it
    // strapped recovery
    assign shutdown_n_o = auto_rec_i ? !fault_oe_i : sd_req_n_i;

    // Gain pins change one edge after the request, like a board register
    always_ff @(posedge clk_i) begin
        gain_ff <= gain_i;
    end
    assign gain_lsb_o = gain_ff[0];
    assign gain_msb_o = gain_ff[1];
endmodule : amp_host_model

/* test/amp_gain_shutdown_protection_ctrl_test.sv */
`timescale 1ns/1ps
module amp_gain_shutdown_protection_ctrl_test;
    logic        clk, rst_n, psel, pen, pwr, sup_ok, shrt, pwm_p, pwm_n;
    logic        auto_rec, sd_req_n, sd_n, g_lsb, g_msb, er, p_oe, n_oe, p_o, n_o, f_oe;
    logic [1:0]  gain, gc;
    logic [7:0]  temp, lim;
    logic [11:0] paddr;
    logic [31:0] pwdata, rd, prdata;
    logic [5:0]  gdb;
    logic        pready, pslverr, f_n;
    int          n_mismatch, checks_done, hp, hn, pc, k;
    // Four-state so an unknown leg level cannot count as a clean zero
    logic [31:0] cnt;

    amp_ctrl_top #(.DC_TRIP_CYCLES(1000)) DUT (
        .CORE_CLK_I(clk), .RESET_N_I(rst_n), .PSEL_I(psel), .PENABLE_I(pen),
        .PWRITE_I(pwr), .PADDR_I(paddr), .PWDATA_I(pwdata), .PSTRB_I(4'hf),
        .PRDATA_O(prdata), .PREADY_O(pready), .PSLVERR_O(pslverr),
        .GAIN_SEL_LSB_I(g_lsb), .GAIN_SEL_MSB_I(g_msb), .SHUTDOWN_N_I(sd_n),
        .BRIDGE_SUPPLY_OK_I(sup_ok), .SHORT_DETECT_I(shrt), .DIE_TEMP_I(temp),
        .PWM_POS_I(pwm_p), .PWM_NEG_I(pwm_n), .BRIDGE_OUT_POS_O(p_o),
        .BRIDGE_OUT_POS_OE_O(p_oe), .BRIDGE_OUT_NEG_O(n_o), .BRIDGE_OUT_NEG_OE_O(n_oe),
        .FAULT_N_O(f_n), .FAULT_N_OE_O(f_oe), .GAIN_DB_O(gdb));

    amp_host_model host (
        .clk_i(clk), .auto_rec_i(auto_rec), .sd_req_n_i(sd_req_n), .fault_oe_i(f_oe),
        .gain_i(gain), .shutdown_n_o(sd_n), .gain_lsb_o(g_lsb), .gain_msb_o(g_msb));

    initial clk = 1'b0;
    always #2.5 clk = ~clk;

    // Modulator stand-in: period of 100, so any 100 cycles hold hp and hn highs
    always @(posedge clk) begin
        pc    <= (pc == 99) ? 0 : pc + 1;
        pwm_p <= pc < hp;
        pwm_n <= pc < hn;
    end

    function automatic logic [5:0] gexp(input logic [1:0] c);
        case (c)
            2'd0: return 6'd20;
            2'd1: return 6'd26;
            2'd2: return 6'd32;
            default: return 6'd36;
        endcase
    endfunction : gexp

    task automatic wt(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : wt

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk

    task automatic report_and_stop();
        $display("comparisons %0d, mismatches %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : report_and_stop

    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int i;
        @(posedge clk);
        psel <= 1'b1; pwr <= w; paddr <= a; pwdata <= d;
        @(posedge clk);
        pen <= 1'b1;
        @(posedge clk);
        i = 0;
        while (pready !== 1'b1) begin
            if (++i > 20) begin
                n_mismatch++;
                report_and_stop();
            end
            @(posedge clk);
        end
        rd = prdata;
        er = pslverr;
        psel <= 1'b0; pen <= 1'b0;
    endtask : apb

    initial begin
        rst_n = 0; psel = 0; pen = 0; pwr = 0; paddr = 0; pwdata = 0; sup_ok = 1;
        shrt = 0; auto_rec = 0; sd_req_n = 0; gain = 0; temp = 8'd25; hp = 50; hn = 50;
        pc = 0; pwm_p = 0; pwm_n = 0; n_mismatch = 0; checks_done = 0;
        void'($urandom(32'hb84e));
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        wt(4);
        @(posedge clk) sd_req_n <= 1'b1;
        wt(4);
        for (k = 0; k < 8; k++) begin
            gc = (k < 4) ? k[1:0] : 2'($urandom % 4);
            @(posedge clk) gain <= gc;
            wt(4);
            chk(gdb, gexp(gc));
        end
        apb(1'b0, 12'h004, 32'h0);
        chk(rd, ({26'h0, gexp(gc)} << 8) | 32'h10);
        $display("gain test done");
        apb(1'b0, 12'h000, 32'h0);
        chk(rd, 32'h0000_6400);
        apb(1'b1, 12'h008, $urandom);
        chk(er, 1'b1);
        chk(rd, 32'h0);
        apb(1'b1, 12'h004, 32'hffff_ffff);
        chk(er, 1'b0);
        lim = 8'(10 + $urandom % 80);
        apb(1'b1, 12'h000, {16'h0, lim, 8'h01});
        @(posedge clk) begin hp <= 100; hn <= 100; end
        wt(200);
        cnt = 0;
        repeat (100) begin
            wt(1);
            cnt += p_o;
        end
        chk(cnt, lim);
        apb(1'b1, 12'h000, 32'h0);
        @(posedge clk) begin hp <= 50; hn <= 50; end
        $display("register and limiter test done");
        @(posedge clk) sd_req_n <= 1'b0;
        wt(3);
        chk({p_oe, n_oe, p_o, n_o, f_oe, f_n}, 6'b110000);
        @(posedge clk) sd_req_n <= 1'b1;
        wt(4);
        @(posedge clk) shrt <= 1'b1;
        wt(3);
        chk({f_oe, p_oe, n_oe}, 3'b100);
        @(posedge clk) shrt <= 1'b0;
        wt(5);
        chk({f_oe, p_oe}, 2'b10);
        @(posedge clk) sd_req_n <= 1'b0;
        wt(3);
        @(posedge clk) sd_req_n <= 1'b1;
        wt(4);
        chk({f_oe, p_oe, n_oe}, 3'b011);
        @(posedge clk) begin auto_rec <= 1'b1; shrt <= 1'b1; end
        @(posedge clk) shrt <= 1'b0;
        wt(10);
        chk({f_oe, p_oe, n_oe}, 3'b011);
        @(posedge clk) auto_rec <= 1'b0;
        $display("shutdown and short test done");
        @(posedge clk) temp <= 8'd150;
        wt(5);
        chk(p_oe, 1'b1);
        @(posedge clk) temp <= 8'd151;
        wt(4);
        chk({f_oe, p_oe, n_oe}, 3'b000);
        @(posedge clk) temp <= 8'd136;
        wt(6);
        chk(p_oe, 1'b0);
        @(posedge clk) temp <= 8'd135;
        wt(6);
        chk({f_oe, p_oe, n_oe}, 3'b011);
        $display("thermal test done");
        @(posedge clk) begin hp <= 57; hn <= 43; end
        wt(2000);
        chk(f_oe, 1'b0);
        @(posedge clk) hp <= 58;
        wt(800);
        chk(f_oe, 1'b0);
        wt(700);
        chk({f_oe, p_oe, n_oe}, 3'b100);
        @(posedge clk) sd_req_n <= 1'b0;
        wt(3);
        @(posedge clk) sd_req_n <= 1'b1;
        wt(4);
        chk({f_oe, p_oe}, 2'b10);
        @(posedge clk) begin hp <= 50; hn <= 50; sd_req_n <= 1'b0; end
        wt(2);
        @(posedge clk) sup_ok <= 1'b0;
        wt(3);
        @(posedge clk) begin sup_ok <= 1'b1; sd_req_n <= 1'b1; end
        wt(5);
        chk({f_oe, p_oe, n_oe}, 3'b011);
        // Negative imbalance first, then a flip must restart the count
        @(posedge clk) begin hp <= 42; hn <= 58; end
        wt(700);
        @(posedge clk) begin hp <= 58; hn <= 42; end
        wt(700);
        chk(f_oe, 1'b0);
        wt(800);
        chk({f_oe, p_oe, n_oe}, 3'b100);
        $display("dc detect test done");
        report_and_stop();
    end
endmodule : amp_gain_shutdown_protection_ctrl_test
